// ---- rtl/csld_pkg.sv ----
// Purpose: constants and types for the charger sense, limit and DAC control block
// Assumes: sys_clk at 200 MHz; comparator inputs already synchronous
// Notes:   all offsets, limits and counts of cycles live here
// What this block does
// R01: overrange detection always runs, both selects off
// R02: near-range mode only after overrange sampled low
// R03: under-range mode only after hot sampled high
// R04: status bits decoded per thermistor range
// R05: adapter absent keeps only overrange detection
// R06: status read refreshes all, then low power
// R07: current select decodes four full-scale ranges
// R08: current ceiling is a hard hardware limit
// R09: voltage select decodes five maximum voltages
// R10: subtract reference from requested voltage
// R11: request below reference programs DAC zero
// R12: above ceiling clamps and sets clamped bit
// R13: current DAC is delta-sigma, 80% max duty
// R14: below 1/16 ceiling uses gated 1/8 pulses
// R15: low-current mode steps about 45 ms per bit
// R16: wake-up holds modulator at 80 mA code
// R17: dropout set above 89% adapter, 2% hysteresis
// R18: dropout forced low without adapter
// R19: adapter or battery change drives alert low
// R20: request at or above ceiling saturates DAC
// R21: wait settling time after switching selects
package csld_pkg;

   localparam int CLK_MHZ        = 200;
   localparam int SETTLE_NS      = 2000;
   localparam int SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int SLOW_BIT_MS    = 45;
   localparam int SLOW_BIT_CYC   = SLOW_BIT_MS * CLK_MHZ * 1000;
   localparam int SCAN_GAP_CYC   = 1024;

   localparam logic [15:0] VREF_MV      = 16'h09A1;   // 2465 mV
   localparam logic [15:0] WAKE_MA      = 16'h0050;   // 80 mA
   localparam logic [9:0]  DAC_FULL     = 10'h3FF;
   localparam logic [10:0] DS_MAX_DUTY  = 11'h333;    // 80% of 1024
   localparam int          FAST_DIV     = 8;
   localparam logic [7:0]  DROP_SET_PCT = 8'h59;      // 89 %
   localparam logic [7:0]  DROP_CLR_PCT = 8'h57;      // 87 %

   typedef enum logic [1:0] {
      CSLD_I1A, CSLD_I2A, CSLD_I4A, CSLD_I8A
   } csld_irange_type;

   typedef enum logic [2:0] {
      CSLD_V8V, CSLD_V12V, CSLD_V16V, CSLD_V21V, CSLD_V32V
   } csld_vrange_type;

   // full-scale current in mA per range
   function automatic logic [15:0] csld_imax(input csld_irange_type r);
      unique case (r)
         CSLD_I1A: csld_imax = 16'h03FF;
         CSLD_I2A: csld_imax = 16'h07FE;
         CSLD_I4A: csld_imax = 16'h0FFC;
         CSLD_I8A: csld_imax = 16'h1FF8;
      endcase
   endfunction : csld_imax

   function automatic logic [15:0] csld_vmax(input csld_vrange_type r);
      unique case (r)
         CSLD_V8V:  csld_vmax = 16'h20F0;
         CSLD_V12V: csld_vmax = 16'h3160;
         CSLD_V16V: csld_vmax = 16'h41E0;
         CSLD_V21V: csld_vmax = 16'h5240;
         default:   csld_vmax = 16'h8000;
      endcase
   endfunction : csld_vmax

   function automatic logic [2:0] csld_vshift(input csld_vrange_type r);
      csld_vshift = (r == CSLD_V8V || r == CSLD_V12V) ? 3'h4 : 3'h5;
   endfunction : csld_vshift

endpackage : csld_pkg

// ---- rtl/csld_dac_if.sv ----
// Purpose: carries the current DAC request from control to the modulator
// Assumes: one clock domain
// Notes:   code is a fraction of full scale out of 1024
`timescale 1ns/10ps
interface csld_dac_if;
   logic [9:0] code;
   logic       lowMode;
   logic       dacOut;

   modport ctrl
   (
      output code,
      output lowMode,
      input  dacOut
   );
   modport mod
   (
      input  code,
      input  lowMode,
      output dacOut
   );
endinterface : csld_dac_if

// ---- rtl/csld_delta_sigma.sv ----
// Purpose: first-order delta-sigma current DAC with low-current mode
// Assumes: code already clamped to full scale
// Notes:   duty is code*0.8/1024 in normal mode
`timescale 1ns/10ps
module csld_delta_sigma
(
   input  wire logic   sys_clk,
   input  wire logic   rst_n,
   csld_dac_if.mod     dac
);
   logic [10:0] acc_q;
   logic [10:0] sum;
   logic [31:0] slowCnt_q;
   logic [2:0]  fastCnt_q;
   logic        step;
   logic        bit_q;
   logic [10:0] scaled;
   logic        out_q;

   // scale to 80% so full scale never exceeds the maximum duty  [R13]
   assign scaled = 11'((({1'b0, dac.code} * 21'(csld_pkg::DS_MAX_DUTY)) >> 10));
   assign step   = dac.lowMode ? (slowCnt_q == 32'(csld_pkg::SLOW_BIT_CYC - 1)) : 1'b1;
   // low mode passes only 1/8 of the time, so the bit density is raised eightfold  [R14]
   assign sum    = acc_q + (dac.lowMode ? {1'b0, dac.code[6:0], 3'h0} : scaled);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         slowCnt_q <= 32'h0;
      else if (!dac.lowMode || step)
         slowCnt_q <= 32'h0;
      else
         slowCnt_q <= slowCnt_q + 32'h1;   // [R15]
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_q <= 11'h0;
         bit_q <= 1'b0;
      end
      else if (step)
      begin
         bit_q <= sum[10];                 // [R13]
         acc_q <= {1'b0, sum[9:0]};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         fastCnt_q <= 3'h0;
      else
         fastCnt_q <= fastCnt_q + 3'h1;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         out_q <= 1'b0;
      else if (dac.lowMode)
         out_q <= bit_q && (fastCnt_q == 3'h0);   // [R14]
      else
         out_q <= bit_q;
   end

   assign dac.dacOut = out_q;

endmodule : csld_delta_sigma

// ---- rtl/csld_control.sv ----
// Purpose: thermistor sequencing, limit decode, voltage code, current DAC control
// Assumes: comparator outputs and selects synchronous to sys_clk
// Notes:   requests in mV and mA, 16 bits each
`timescale 1ns/10ps
module csld_control
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        adapterDetected,
   input  wire logic        statusReadStart,
   input  wire logic        statusReadDone,
   input  wire logic        overrangeCmp,
   input  wire logic        coldCmp,
   input  wire logic        hotCmp,
   input  wire logic        underrangeCmp,
   input  wire logic [1:0]  currentCeilingSelect,
   input  wire logic [2:0]  voltageCeilingSelect,
   input  wire logic [15:0] reqVoltage,
   input  wire logic [15:0] reqCurrent,
   input  wire logic        wakeUp,
   input  wire logic [7:0]  batteryPct,
   output logic             nearRangeSwitchSel_n,
   output logic             underRangeSwitchSel_n,
   output logic             thermOverrangeFlag,
   output logic             flagA,
   output logic             flagB,
   output logic             thermUnderrangeFlag,
   output logic             batteryDetected,
   output logic             thermStatusValid,
   output logic             adapterDropoutFlag,
   output logic             voltageClampedFlag,
   output logic [10:0]      voltageDacCode,
   output logic             currentDacOut,
   output logic             hostAlert_n
);
   typedef enum logic [2:0] {
      T_OVER, T_NEAR_SETTLE, T_NEAR, T_UNDER_SETTLE, T_UNDER, T_IDLE
   } csld_thermistor_sense_input_type;

   csld_thermistor_sense_input_type   state_q;
   csld_thermistor_sense_input_type   state_d;
   logic [15:0]      cnt_q;
   logic             settleDone;
   logic             gapDone;
   logic             lowPower;
   logic             readReq_q;
   logic             nearSel_n_q;
   logic             underSel_n_q;
   logic             orFlag_q;
   logic             hot_q;
   logic             cold_q;
   logic             coldSeen_q;
   logic             ur_q;
   logic             batDet_q;
   logic             valid_q;
   logic             dropout_q;
   logic             vclamp_q;
   logic [10:0]      vcode_q;
   logic             alert_n_q;
   logic             primed_q;
   logic             prevAdapter_q;
   logic             prevBat_q;
   logic [15:0]      vEff;
   logic [15:0]      vDiff;
   logic [15:0]      vSteps;
   logic [15:0]      iEff;
   logic [15:0]      iSteps;
   logic             iLow;
   logic [9:0]       dacCode_q;
   logic             dacLow_q;
   logic             dacOut_q;

   csld_dac_if dacBus ();

   csld_delta_sigma u_ds
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .dac     (dacBus.mod)
   );

   // decoded ceilings  [R07] [R09]
   csld_pkg::csld_irange_type irange;
   csld_pkg::csld_vrange_type vrange;
   logic [15:0]               imax;
   logic [15:0]               vmax;
   assign irange = csld_pkg::csld_irange_type'(currentCeilingSelect);
   assign vrange = (voltageCeilingSelect > 3'h4) ? csld_pkg::CSLD_V32V
                 : csld_pkg::csld_vrange_type'(voltageCeilingSelect);
   assign imax   = csld_pkg::csld_imax(irange);
   assign vmax   = csld_pkg::csld_vmax(vrange);

   // sequencer timing
   assign lowPower   = !adapterDetected && !readReq_q;   // [R05]
   assign settleDone = (cnt_q == 16'(csld_pkg::SETTLE_CYC - 1));   // [R21]
   assign gapDone    = (cnt_q == 16'(csld_pkg::SCAN_GAP_CYC - 1));

   // a status read forces full scans until it completes
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         readReq_q <= 1'b0;
      else if (statusReadStart)
         readReq_q <= 1'b1;   // [R06]
      else if (statusReadDone)
         readReq_q <= 1'b0;   // [R06]
   end

   // next scan step
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         T_OVER:
         begin
            if (settleDone)
            begin
               if (overrangeCmp || lowPower)
                  state_d = T_IDLE;   // [R05]
               else
                  state_d = T_NEAR_SETTLE;   // [R02]
            end
         end
         T_NEAR_SETTLE:
         begin
            if (lowPower)
               state_d = T_IDLE;   // [R05]
            else if (settleDone)
               state_d = T_NEAR;   // [R21]
         end
         T_NEAR:
         begin
            if (hotCmp)
               state_d = T_UNDER_SETTLE;   // [R03]
            else
               state_d = T_IDLE;
         end
         T_UNDER_SETTLE:
         begin
            if (lowPower)
               state_d = T_IDLE;   // [R05]
            else if (settleDone)
               state_d = T_UNDER;   // [R21]
         end
         T_UNDER:
            state_d = T_IDLE;
         T_IDLE:
         begin
            if (gapDone || statusReadStart)
               state_d = T_OVER;   // [R06]
         end
         default:
            state_d = T_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= T_OVER;
      else
         state_q <= state_d;
   end

   // settle and gap timer restarts on every state change
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= 16'h0000;
      else if (state_d != state_q)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_q + 16'h0001;
   end

   // selects follow the next state; both off outside the range tests
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nearSel_n_q  <= 1'b1;
         underSel_n_q <= 1'b1;
      end
      else
      begin
         nearSel_n_q  <= !(state_d == T_NEAR_SETTLE || state_d == T_NEAR);     // [R01] [R02]
         underSel_n_q <= !(state_d == T_UNDER_SETTLE || state_d == T_UNDER);   // [R01] [R03]
      end
   end

   // full-scan results commit together with a one-cycle valid strobe; a low-power exit sets only overrange and battery bits, no strobe
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         orFlag_q   <= 1'b0;
         hot_q      <= 1'b0;
         cold_q     <= 1'b0;
         ur_q       <= 1'b0;
         batDet_q   <= 1'b0;
         valid_q    <= 1'b0;
         coldSeen_q <= 1'b0;
      end
      else
      begin
         valid_q <= 1'b0;
         unique case (state_q)
            T_OVER:
            begin
               if (settleDone && overrangeCmp)
               begin
                  orFlag_q <= 1'b1;   // [R01] [R04]
                  cold_q   <= 1'b1;
                  hot_q    <= 1'b0;
                  ur_q     <= 1'b0;
                  batDet_q <= 1'b0;
                  valid_q  <= 1'b1;
               end
               else if (settleDone && lowPower)
               begin
                  orFlag_q <= 1'b0;   // [R05]
                  batDet_q <= 1'b1;
               end
            end
            T_NEAR:
            begin
               coldSeen_q <= coldCmp;   // [R02]
               if (!hotCmp)
               begin
                  orFlag_q <= 1'b0;   // [R04]
                  cold_q   <= coldCmp;
                  hot_q    <= 1'b0;
                  ur_q     <= 1'b0;
                  batDet_q <= 1'b1;
                  valid_q  <= 1'b1;
               end
            end
            T_UNDER:
            begin
               orFlag_q <= 1'b0;   // [R04]
               cold_q   <= coldSeen_q;
               hot_q    <= 1'b1;
               ur_q     <= underrangeCmp;   // [R03]
               batDet_q <= 1'b1;
               valid_q  <= 1'b1;
            end
            default:
            begin
            end
         endcase
      end
   end

   // dropout with a hysteresis band between the two thresholds
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         dropout_q <= 1'b0;
      else if (!adapterDetected)
         dropout_q <= 1'b0;   // [R18]
      else if (batteryPct > csld_pkg::DROP_SET_PCT)
         dropout_q <= 1'b1;   // [R17]
      else if (batteryPct < csld_pkg::DROP_CLR_PCT)
         dropout_q <= 1'b0;   // [R17]
   end

   // voltage code: clamp, remove the reference offset, scale to steps
   assign vEff   = (reqVoltage > vmax) ? vmax : reqVoltage;   // [R12]
   assign vDiff  = (vEff < csld_pkg::VREF_MV) ? 16'h0000 : vEff - csld_pkg::VREF_MV;   // [R10] [R11]
   assign vSteps = vDiff >> csld_pkg::csld_vshift(vrange);   // [R09]

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vcode_q  <= 11'h000;
         vclamp_q <= 1'b0;
      end
      else
      begin
         vcode_q  <= vSteps[10:0];
         vclamp_q <= (reqVoltage > vmax);   // [R12]
      end
   end

   // current request: wake-up overrides, ceiling is never exceeded
   assign iEff   = wakeUp ? csld_pkg::WAKE_MA : ((reqCurrent >= imax) ? imax : reqCurrent);   // [R08] [R16]
   assign iSteps = iEff >> currentCeilingSelect;   // [R07]
   assign iLow   = ({iEff, 4'h0} < {4'h0, imax});   // [R14]

   // code is the request in steps of the decoded range
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dacCode_q <= 10'h000;
         dacLow_q  <= 1'b0;
      end
      else
      begin
         if (!wakeUp && reqCurrent >= imax)
            dacCode_q <= csld_pkg::DAC_FULL;   // [R20]
         else
            dacCode_q <= iSteps[9:0];   // [R13] [R16]
         dacLow_q <= iLow;   // [R14]
      end
   end

   assign dacBus.code    = dacCode_q;
   assign dacBus.lowMode = dacLow_q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         dacOut_q <= 1'b0;
      else
         dacOut_q <= dacBus.dacOut;
   end

   // change detectors are primed one cycle so reset makes no false edge
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         primed_q      <= 1'b0;
         prevAdapter_q <= 1'b0;
         prevBat_q     <= 1'b0;
      end
      else
      begin
         primed_q      <= 1'b1;
         prevAdapter_q <= adapterDetected;
         prevBat_q     <= batDet_q;
      end
   end

   // a new change wins over a read that would clear the alert
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         alert_n_q <= 1'b1;
      else if (primed_q && ((prevAdapter_q != adapterDetected) || (prevBat_q != batDet_q)))
         alert_n_q <= 1'b0;   // [R19]
      else if (statusReadDone)
         alert_n_q <= 1'b1;
   end

   // outputs straight from flip-flops
   assign nearRangeSwitchSel_n  = nearSel_n_q;
   assign underRangeSwitchSel_n = underSel_n_q;
   assign thermOverrangeFlag    = orFlag_q;
   assign flagA                 = hot_q;
   assign flagB                 = cold_q;
   assign thermUnderrangeFlag   = ur_q;
   assign batteryDetected       = batDet_q;
   assign thermStatusValid      = valid_q;
   assign adapterDropoutFlag    = dropout_q;
   assign voltageClampedFlag    = vclamp_q;
   assign voltageDacCode        = vcode_q;
   assign currentDacOut         = dacOut_q;
   assign hostAlert_n           = alert_n_q;

endmodule : csld_control

// ---- testbench/csld_control_properties.sv ----
// Purpose: port properties of the sense block
// Assumes: one clock, async low reset
// Notes:   voltage checks wait 8 quiet cycles
`timescale 1ns/10ps
module csld_control_properties
(
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        adapterDetected,
   input wire logic [2:0]  voltageCeilingSelect,
   input wire logic [15:0] reqVoltage,
   input wire logic        nearRangeSwitchSel_n,
   input wire logic        underRangeSwitchSel_n,
   input wire logic        thermOverrangeFlag,
   input wire logic        flagA,
   input wire logic        flagB,
   input wire logic        thermUnderrangeFlag,
   input wire logic        batteryDetected,
   input wire logic        adapterDropoutFlag,
   input wire logic        voltageClampedFlag,
   input wire logic [10:0] voltageDacCode,
   input wire logic        hostAlert_n
);
   wire logic [15:0] vLim =
      csld_pkg::csld_vmax(csld_pkg::csld_vrange_type'(voltageCeilingSelect));
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_sel; nearRangeSwitchSel_n || underRangeSwitchSel_n; endproperty
   a_sel: assert property (p_sel) else $error("both selects on");
   property p_off; $fell(adapterDetected) |->
      ##[1:1000] (nearRangeSwitchSel_n && underRangeSwitchSel_n); endproperty
   a_off: assert property (p_off) else $error("selects on in low power");
   property p_or; thermOverrangeFlag |-> flagB && !batteryDetected; endproperty
   a_or: assert property (p_or) else $error("overrange bits wrong");
   property p_ur; thermUnderrangeFlag |-> flagA && batteryDetected; endproperty
   a_ur: assert property (p_ur) else $error("underrange bits wrong");
   property p_drop; !adapterDetected [*4] |-> !adapterDropoutFlag; endproperty
   a_drop: assert property (p_drop) else $error("dropout without adapter");
   property p_zero; $stable(reqVoltage) [*8] ##0 (reqVoltage < csld_pkg::VREF_MV)
      |-> voltageDacCode == 11'h000; endproperty
   a_zero: assert property (p_zero) else $error("code not zero");
   property p_clamp; $stable({reqVoltage, vLim}) [*8] ##0 (reqVoltage > vLim)
      |-> voltageClampedFlag; endproperty
   a_clamp: assert property (p_clamp) else $error("clamp bit low");
   property p_alert; $changed(adapterDetected) || $changed(batteryDetected)
      |-> ##[0:8] !hostAlert_n; endproperty
   a_alert: assert property (p_alert) else $error("no alert");
endmodule : csld_control_properties
bind csld_control csld_control_properties i_csld_control_properties (.*);

// ---- testbench/csld_thermistor_sense_input_model.sv ----
// Purpose: thermistor network and comparators
// Assumes: thermistor value in ohms
// Notes:   an unselected comparator toggles
`timescale 1ns/10ps
module csld_thermistor_sense_input_model
(
   input  wire logic        sys_clk,
   input  wire logic        nearRangeSwitchSel_n,
   input  wire logic        underRangeSwitchSel_n,
   input  wire logic [31:0] ohms,
   output logic             overrangeCmp = 1'b0,
   output logic             coldCmp = 1'b0,
   output logic             hotCmp = 1'b0,
   output logic             underrangeCmp = 1'b0
);
   wire logic idle = nearRangeSwitchSel_n && underRangeSwitchSel_n;
   always @(posedge sys_clk)
   begin
      overrangeCmp <= idle ? ohms > 32'h186A0 : !overrangeCmp;
      coldCmp <= !nearRangeSwitchSel_n ? ohms > 32'h7530 : !coldCmp;
      hotCmp <= !nearRangeSwitchSel_n ? ohms < 32'hBB8 : !hotCmp;
      underrangeCmp <= !underRangeSwitchSel_n ? ohms < 32'h1F4 : !underrangeCmp;
   end
endmodule : csld_thermistor_sense_input_model

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for the sense block
// Assumes: thermistor modelled in ohms
// Notes:   status checked once a scan settled
`timescale 1ns/10ps
module testbench;
   logic sys_clk = 1'b0, rst_n = 1'b0, adapterDetected = 1'b1, wakeUp = 1'b0;
   logic statusReadStart = 1'b0, statusReadDone = 1'b0;
   logic [1:0] currentCeilingSelect = 2'h0;
   logic [2:0] voltageCeilingSelect = 3'h0;
   logic [15:0] reqVoltage = 16'h0000, reqCurrent = 16'h0000;
   logic [7:0] batteryPct = 8'h00;
   logic [31:0] ohms = 32'h2710;
   logic overrangeCmp, coldCmp, hotCmp, underrangeCmp, nearRangeSwitchSel_n;
   logic underRangeSwitchSel_n, thermOverrangeFlag, flagA, flagB, thermUnderrangeFlag;
   logic batteryDetected, thermStatusValid, adapterDropoutFlag, voltageClampedFlag;
   logic currentDacOut, hostAlert_n;
   logic [10:0] voltageDacCode;
   logic [7:0] expQ[$];
   int failures = 0, compares = 0, cycles = 0, dacOnes = 0;
   localparam logic [31:0] RES[5] = '{32'hC8, 32'h3E8, 32'h2710, 32'hC350, 32'h30D40};
   localparam logic [4:0] FLG[5] = '{5'h19, 5'h09, 5'h01, 5'h05, 5'h06};
   localparam logic [15:0] VMAX[5] = '{16'h20F0, 16'h3160, 16'h41E0, 16'h5240, 16'h8000};
   wire logic [7:0] seen = {thermUnderrangeFlag, flagA, flagB, thermOverrangeFlag,
      batteryDetected, voltageClampedFlag, voltageDacCode == 11'h000, adapterDropoutFlag};
   csld_control i_csld_control (.*);
   csld_thermistor_sense_input_model i_csld_thermistor_sense_input_model (.*);
   always #2.5 sys_clk = ~sys_clk;
   task automatic results;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   task automatic check(input logic [7:0] got, input logic [7:0] want);
      compares++;
      if (got !== want)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, got, want);
      end
   endtask : check
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         failures++;
         results();
      end
      if (thermStatusValid === 1'b1 && expQ.size() > 0)
         check(seen, expQ.pop_front());
   end
   initial
   begin
      void'($urandom(32'h5B17));
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         @(posedge sys_clk);
         ohms <= RES[i % 5];
         voltageCeilingSelect <= 3'($urandom_range(4));
         reqVoltage <= (i == 0) ? 16'h0100 : 16'($urandom_range(40000));
         batteryPct <= (i % 2) ? 8'h5F : 8'h50;
         currentCeilingSelect <= 2'($urandom);
         reqCurrent <= 16'($urandom_range(9000));
         wakeUp <= (i % 3 == 0);
         repeat (3 * csld_pkg::SCAN_GAP_CYC) @(posedge sys_clk);
         expQ.push_back({FLG[i % 5], reqVoltage > VMAX[voltageCeilingSelect],
            reqVoltage <= 16'h09A1, batteryPct == 8'h5F});
         while (expQ.size() > 0) @(posedge sys_clk);
         $display("test %0d done", i);
      end
      wakeUp <= 1'b0;
      currentCeilingSelect <= 2'h0;
      reqCurrent <= 16'h1000;
      repeat (32) @(posedge sys_clk);
      repeat (1024) @(posedge sys_clk) dacOnes += currentDacOut;
      check({7'h0, (dacOnes >= 810 && dacOnes <= 826)}, 8'h01);
      $display("current dac done");
      adapterDetected <= 1'b0;
      repeat (1200) @(posedge sys_clk);
      $display("adapter removal done");
      ohms <= 32'h2710;
      repeat (2 * csld_pkg::SCAN_GAP_CYC) @(posedge sys_clk);
      expQ.push_back({5'h01, reqVoltage > VMAX[voltageCeilingSelect],
         reqVoltage <= 16'h09A1, 1'b0});
      statusReadStart <= 1'b1;
      @(posedge sys_clk);
      statusReadStart <= 1'b0;
      while (expQ.size() > 0) @(posedge sys_clk);
      statusReadDone <= 1'b1;
      @(posedge sys_clk);
      statusReadDone <= 1'b0;
      $display("status read done");
      results();
   end
endmodule : testbench
